// File: design/ee_defines.svh
`ifndef EE_DEFINES_SVH
`define EE_DEFINES_SVH

// system clock rate
`define EE_CLK_HZ 50000000
// internal nonvolatile write time, milliseconds
`define EE_WRITE_TIME_MS 5
// power-up to ready delay, milliseconds
`define EE_POWERUP_TIME_MS 1
// longest times round down to whole cycles
`define EE_WRITE_CYCLES (`EE_WRITE_TIME_MS * (`EE_CLK_HZ / 1000))
`define EE_POWERUP_CYCLES (`EE_POWERUP_TIME_MS * (`EE_CLK_HZ / 1000))
// busy timer width, holds the write count
`define EE_TIMER_W 18
// bytes in one page buffer
`define EE_PAGE_BYTES 16
// erased cell content
`define EE_ERASED 8'hff
// bit counter values: eighth data bit, acknowledge slot
`define EE_LAST_BIT 4'h7
`define EE_ACK_SLOT 4'h8

`endif

// File: design/ee_pkg.sv
`include "ee_defines.svh"

package ee_pkg;

  // serial link states
  typedef enum logic [2:0] {
    LK_IDLE,
    LK_DEVADR,
    LK_WORDADR,
    LK_WDATA,
    LK_RDATA
  } ee_link_state_t;

  // state clocked by the rising serial clock, apart from the page buffer
  typedef struct packed {
    ee_link_state_t state;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [8:0] ptr;
    logic rw;
    logic ack_flag;
    logic wp_lat;
    logic data_seen;
    logic req_tog;
    logic start_seen;
    logic [`EE_PAGE_BYTES-1:0] vmask;
    logic wp_s1;
    logic wp_s2;
    logic [2:0] strap_s1;
    logic [2:0] strap_s2;
    logic busy_s1;
    logic busy_s2;
  } ee_link_t;

  // state clocked by the falling serial clock
  typedef struct packed {
    logic oe;
  } ee_drive_t;

  // system clock state
  typedef struct packed {
    logic stop_s1;
    logic stop_s2;
    logic stop_s3;
    logic req_s1;
    logic req_s2;
    logic req_ack;
    logic busy;
    logic [`EE_TIMER_W-1:0] timer;
  } ee_sys_t;

endpackage

// File: design/ee_slave.sv
`timescale 1ns/100ps
`include "ee_defines.svh"

module ee_slave
  import ee_pkg::*;
#(
  parameter bit WIDE_ARRAY = 1'b1, // 1: 512 bytes, 0: 256 bytes
  parameter logic [3:0] DEV_TYPE = 4'h5, // arbitrary value
  parameter int unsigned WRITE_CYCLES = `EE_WRITE_CYCLES,
  parameter int unsigned POWERUP_CYCLES = `EE_POWERUP_CYCLES
)(
  input wire logic clk_in, // system clock
  input wire logic sys_rst_in, // power-on reset, async high
  input wire logic ce_in, // clock enable, freezes all state
  input wire logic scl_in, // serial clock from the master
  input wire logic sda_in, // serial data line level
  output logic sda_out, // serial data drive value
  output logic sda_oe_out, // high while pulling data low
  input wire logic addr_strap_0, // address strap, low select bit
  input wire logic addr_strap_1, // address strap
  input wire logic addr_strap_2, // address strap, high select bit
  input wire logic wp_in, // write protect for the upper half
  output logic write_busy_out // internal write or power-up busy
);

  localparam int AW = WIDE_ARRAY ? 9 : 8;
  localparam int DEPTH = 1 << AW;
  localparam logic [8:0] AMASK = 9'(DEPTH - 1);

  ee_link_t lk_reg;
  ee_link_t lk_next;
  ee_drive_t dr_reg;
  ee_drive_t dr_next;
  ee_sys_t sy_reg;
  ee_sys_t sy_next;

  logic [7:0] mem [DEPTH];
  logic [7:0] pbuf [`EE_PAGE_BYTES];
  logic start_tog_reg;
  logic stop_tog_reg;
  logic start_ev;
  logic match_now;
  logic protect_now;
  logic rx_state;
  logic buf_we;
  logic commit;
  logic [7:0] byte_in;
  logic [7:0] rd_byte;

  // pointer step for reads, wraps at the end of the whole array
  function automatic logic [8:0] wrap_inc(input logic [8:0] p);
    wrap_inc = (p + 9'h001) & AMASK;
  endfunction

  // conditions seen on data edges while the clock is high
  always_ff @(negedge sda_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      start_tog_reg <= 1'b0;
    else if (ce_in && scl_in)
      start_tog_reg <= ~start_tog_reg;
  end

  // a stop only ends commands; the link learns of it at the next start
  always_ff @(posedge sda_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      stop_tog_reg <= 1'b0;
    else if (ce_in && scl_in)
      stop_tog_reg <= ~stop_tog_reg;
  end

  // toggle settles during the high phase, long before the next rise
  assign start_ev = start_tog_reg != lk_reg.start_seen;
  assign byte_in = {lk_reg.shreg[6:0], sda_in};
  assign rd_byte = mem[lk_reg.ptr[AW-1:0]];

  // straps come from pads with pull-downs, so open pins read low
  assign match_now = (byte_in[7:4] == DEV_TYPE)
    && (byte_in[3] == lk_reg.strap_s2[2])
    && (byte_in[2] == lk_reg.strap_s2[1])
    && (WIDE_ARRAY || (byte_in[1] == lk_reg.strap_s2[0]))
    && !lk_reg.busy_s2;

  // upper half is the top address bit set, under a latched protect
  assign protect_now = lk_reg.wp_lat && lk_reg.ptr[AW-1];

  assign rx_state = (lk_reg.state == LK_DEVADR)
    || (lk_reg.state == LK_WORDADR) || (lk_reg.state == LK_WDATA);

  // link engine, acts on each rising serial clock
  always_comb
  begin
    lk_next = lk_reg;
    buf_we = 1'b0;
    lk_next.wp_s1 = wp_in;
    lk_next.wp_s2 = lk_reg.wp_s1;
    lk_next.strap_s1 = {addr_strap_2, addr_strap_1, addr_strap_0};
    lk_next.strap_s2 = lk_reg.strap_s1;
    lk_next.busy_s1 = sy_reg.busy;
    lk_next.busy_s2 = lk_reg.busy_s1;
    if (start_ev)
    begin
      // first address bit is sampled on this same edge
      lk_next.start_seen = start_tog_reg;
      lk_next.state = LK_DEVADR;
      lk_next.shreg = {7'h00, sda_in};
      lk_next.cnt = 4'h1;
    end
    else if (rx_state && lk_reg.cnt != `EE_ACK_SLOT)
    begin
      lk_next.shreg = byte_in;
      lk_next.cnt = lk_reg.cnt + 4'h1;
    end
    if (!start_ev)
    begin
      unique case (lk_reg.state)
        LK_IDLE:
        begin
          lk_next.ack_flag = 1'b0;
        end
        LK_DEVADR:
        begin
          if (lk_reg.cnt == `EE_LAST_BIT)
          begin
            lk_next.ack_flag = match_now;
            lk_next.rw = byte_in[0];
            if (WIDE_ARRAY && match_now)
              lk_next.ptr[8] = byte_in[1];
          end
          else if (lk_reg.cnt == `EE_ACK_SLOT)
          begin
            lk_next.cnt = 4'h0;
            if (!lk_reg.ack_flag)
              lk_next.state = LK_IDLE;
            else if (lk_reg.rw)
            begin
              lk_next.state = LK_RDATA;
              lk_next.shreg = rd_byte;
              lk_next.ptr = wrap_inc(lk_reg.ptr);
            end
            else
              lk_next.state = LK_WORDADR;
          end
        end
        LK_WORDADR:
        begin
          if (lk_reg.cnt == `EE_LAST_BIT)
          begin
            lk_next.ptr[7:0] = byte_in;
            lk_next.ack_flag = 1'b1;
          end
          else if (lk_reg.cnt == `EE_ACK_SLOT)
          begin
            // this edge ends the ack slot; the next fall starts data
            lk_next.cnt = 4'h0;
            lk_next.state = LK_WDATA;
            lk_next.wp_lat = lk_reg.wp_s2;
            lk_next.data_seen = 1'b0;
            lk_next.vmask = '0;
          end
        end
        LK_WDATA:
        begin
          if (lk_reg.cnt == `EE_LAST_BIT)
          begin
            if (protect_now)
              lk_next.ack_flag = 1'b0;
            else
            begin
              lk_next.ack_flag = 1'b1;
              buf_we = 1'b1;
              lk_next.vmask[lk_reg.ptr[3:0]] = 1'b1;
              lk_next.ptr[3:0] = lk_reg.ptr[3:0] + 4'h1;
              lk_next.data_seen = 1'b1;
              if (!lk_reg.data_seen)
                lk_next.req_tog = ~lk_reg.req_tog;
            end
          end
          else if (lk_reg.cnt == `EE_ACK_SLOT)
          begin
            lk_next.cnt = 4'h0;
            if (!lk_reg.ack_flag)
              lk_next.state = LK_IDLE;
          end
        end
        LK_RDATA:
        begin
          if (lk_reg.cnt == `EE_ACK_SLOT)
          begin
            lk_next.cnt = 4'h0;
            if (!sda_in)
            begin
              lk_next.shreg = rd_byte;
              lk_next.ptr = wrap_inc(lk_reg.ptr);
            end
            else
              lk_next.state = LK_IDLE;
          end
          else
          begin
            lk_next.shreg = {lk_reg.shreg[6:0], 1'b0};
            lk_next.cnt = lk_reg.cnt + 4'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge scl_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      lk_reg <= '0;
    else if (ce_in)
      lk_reg <= lk_next;
  end

  // page buffer, later bytes of a wrapped page overwrite earlier ones
  always @(posedge scl_in)
  begin
    if (ce_in && buf_we && !start_ev)
      pbuf[lk_reg.ptr[3:0]] <= byte_in;
  end

  // line drive decided from the link state, changed on the fall
  always_comb
  begin
    dr_next.oe = ((lk_reg.state == LK_RDATA)
      && (lk_reg.cnt != `EE_ACK_SLOT) && !lk_reg.shreg[7])
      || (rx_state && (lk_reg.cnt == `EE_ACK_SLOT)
      && lk_reg.ack_flag);
  end

  always_ff @(negedge scl_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      dr_reg <= '0;
    else if (ce_in)
      dr_reg <= dr_next;
  end

  // only ever pull low, the pull-up gives the ones
  assign sda_out = 1'b0;
  assign sda_oe_out = dr_reg.oe;
  assign write_busy_out = sy_reg.busy;

  // stop seen here commits the buffered page and runs the busy timer
  assign commit = (sy_reg.stop_s2 != sy_reg.stop_s3)
    && (sy_reg.req_s2 != sy_reg.req_ack) && !sy_reg.busy;

  always_comb
  begin
    sy_next = sy_reg;
    sy_next.stop_s1 = stop_tog_reg;
    sy_next.stop_s2 = sy_reg.stop_s1;
    sy_next.stop_s3 = sy_reg.stop_s2;
    sy_next.req_s1 = lk_reg.req_tog;
    sy_next.req_s2 = sy_reg.req_s1;
    if (sy_reg.busy)
    begin
      sy_next.timer = sy_reg.timer - `EE_TIMER_W'(1);
      if (sy_reg.timer == `EE_TIMER_W'(1))
        sy_next.busy = 1'b0;
    end
    if (commit)
    begin
      sy_next.busy = 1'b1;
      sy_next.timer = `EE_TIMER_W'(WRITE_CYCLES);
      sy_next.req_ack = sy_reg.req_s2;
    end
  end

  // busy through the power-up delay before the first command
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      sy_reg <= '{busy: 1'b1, timer: `EE_TIMER_W'(POWERUP_CYCLES),
        default: '0};
    else if (ce_in)
      sy_reg <= sy_next;
  end

  // array: erased at start; the link is idle while a page is written,
  // so the buffer, mask and page bits are steady here
  initial
  begin
    for (int i = 0; i < DEPTH; i++)
      mem[i] = `EE_ERASED;
  end

  always @(posedge clk_in)
  begin
    if (ce_in && commit)
    begin
      for (int i = 0; i < `EE_PAGE_BYTES; i++)
      begin
        if (lk_reg.vmask[i])
          mem[{lk_reg.ptr[AW-1:4], 4'(i)}] <= pbuf[i];
      end
    end
  end

  sequence dev_last_bit;
    !start_ev && lk_reg.state == LK_DEVADR && lk_reg.cnt == 4'h7;
  endsequence

  sequence wdata_last_bit;
    !start_ev && lk_reg.state == LK_WDATA && lk_reg.cnt == 4'h7;
  endsequence

  // flag set on the eighth rise, already on the line at the ninth
  property p_ack_match;
    @(posedge scl_in) disable iff (sys_rst_in)
    (dev_last_bit and (ce_in && match_now)) |=>
    lk_reg.ack_flag && sda_oe_out;
  endproperty

  ack_on_match_a: assert property (p_ack_match)
    else $error("matching address not acknowledged");

  busy_no_ack_a: assert property (
    @(posedge scl_in) disable iff (sys_rst_in)
    (dev_last_bit and (ce_in && lk_reg.busy_s2)) |=> !lk_reg.ack_flag)
    else $error("address acknowledged while busy");

  page_wrap_a: assert property (
    @(posedge scl_in) disable iff (sys_rst_in)
    (wdata_last_bit and (ce_in && !protect_now)) |=>
    lk_reg.ptr[8:4] == $past(lk_reg.ptr[8:4])
    && lk_reg.ptr[3:0] == $past(lk_reg.ptr[3:0]) + 4'h1)
    else $error("page pointer step wrong");

  wp_reject_a: assert property (
    @(posedge scl_in) disable iff (sys_rst_in)
    (wdata_last_bit and (ce_in && protect_now)) |=>
    !lk_reg.ack_flag && !sda_oe_out ##1 !sda_oe_out)
    else $error("protected data byte acknowledged");

  read_step_a: assert property (
    @(posedge scl_in) disable iff (sys_rst_in)
    (ce_in && !start_ev && lk_reg.state == LK_RDATA
    && lk_reg.cnt == 4'h8 && !sda_in) |=>
    lk_reg.ptr == wrap_inc($past(lk_reg.ptr)))
    else $error("read pointer step wrong");

  start_hunt_a: assert property (
    @(posedge scl_in) disable iff (sys_rst_in)
    (ce_in && start_ev) |=> lk_reg.state == LK_DEVADR
    && lk_reg.cnt == 4'h1)
    else $error("start not taken");

  read_release_a: assert property (
    @(posedge scl_in) disable iff (sys_rst_in)
    (lk_reg.state == LK_RDATA && lk_reg.cnt == 4'h8) |-> !sda_oe_out)
    else $error("line held in read ack slot");

  commit_busy_a: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && commit) |=> sy_reg.busy [*8])
    else $error("write cycle not started at stop");

  busy_end_a: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && sy_reg.busy && sy_reg.timer == 18'h0_0001 && !commit)
    |=> !write_busy_out)
    else $error("busy outlasts its timer");

endmodule // ee_slave

// File: tb/ee_master_model.sv
`timescale 1ns/100ps
// bus master: serial clock runs only inside frames, stands high between
module ee_master_model
(
  input wire logic sda_in, // resolved data line
  output logic scl_out, // serial clock
  output logic sda_low_out // high pulls data low
);
  localparam int HALF = 24;

  initial
  begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  // start or repeated start, clock left low
  task automatic start();
    #2 sda_low_out = 1'b0;
    #(HALF - 2) scl_out = 1'b1;
    #HALF sda_low_out = 1'b1;
    #HALF scl_out = 1'b0;
  endtask

  // data changes only while the clock is low, just after the fall, so
  // no data edge can share a time step with a clock edge
  task automatic bit_xfer(input logic b, output logic s);
    #2 sda_low_out = ~b;
    #(HALF - 2) scl_out = 1'b1;
    #1 s = sda_in;
    #(HALF - 1) scl_out = 1'b0;
  endtask

  // ack comes back 0, nack 1
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_xfer(d[i], s);
    bit_xfer(1'b1, ack);
  endtask

  // last byte of a read is answered with nack
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_xfer(1'b1, s);
      d[i] = s;
    end
    bit_xfer(nack, s);
  endtask

  // clock held high long enough for the slow side to see the stop
  task automatic stop();
    #2 sda_low_out = 1'b1;
    #(HALF - 2) scl_out = 1'b1;
    #HALF sda_low_out = 1'b0;
    #120;
  endtask
endmodule // ee_master_model

// File: tb/i2c_eeprom_slave_interface_tb.sv
`timescale 1ns/100ps
module i2c_eeprom_slave_interface_tb;
  localparam logic [3:0] DT = 4'h5; // arbitrary type code
  localparam logic [2:0] STRAP = 3'b110;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic wp_in = 1'b0;
  logic ce = 1'b1;
  logic [2:0] strap = STRAP;
  logic scl, sda_low, sda_out, sda_oe_out, busy, sda, ack;
  logic [7:0] mem [512];
  logic [31:0] rng = 32'hd2a0148d;
  int error_cnt = 0;
  int total_checks = 0;
  int ptr = 0;
  int n, a;

  always #10 clk_in = ~clk_in;

  // open drain wire with pull-up
  assign sda = ~(sda_low | sda_oe_out);

  ee_slave #(.WRITE_CYCLES(60), .POWERUP_CYCLES(10)) DUT (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .addr_strap_0(strap[0]),
    .addr_strap_1(strap[1]), .addr_strap_2(strap[2]),
    .wp_in(wp_in), .write_busy_out(busy));

  ee_master_model mst (.sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));

  function automatic logic [7:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[7:0];
  endfunction

  function automatic logic [7:0] dev(input logic a8, input logic rw);
    return {DT, STRAP[2:1], a8, rw};
  endfunction

  task automatic cmp_bit(input string what, input logic e, input logic g);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %s: expected %b, seen %b", what, e, g);
    end
  endtask

  task automatic cmp_byte(input string what, input logic [7:0] e,
                          input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask

  // poll until acked, bounded tries; n returns the tries used
  task automatic poll(output int cnt);
    logic k;
    cnt = 0;
    k = 1'b1;
    while (k !== 1'b0 && cnt < 100)
    begin
      mst.start();
      mst.wbyte(dev(1'b0, 1'b0), k);
      mst.stop();
      cnt++;
    end
    cmp_bit("poll ack", 1'b0, k);
  endtask

  // page write of cnt random bytes; model wraps inside the page
  task automatic wr(input int adr, input int cnt, input logic prot);
    logic [7:0] d;
    mst.start();
    mst.wbyte(dev(adr[8], 1'b0), ack);
    cmp_bit("addr ack", 1'b0, ack);
    mst.wbyte(adr[7:0], ack);
    cmp_bit("word ack", 1'b0, ack);
    for (int i = 0; i < cnt; i++)
    begin
      d = rnd();
      mst.wbyte(d, ack);
      cmp_bit("data ack", prot, ack);
      if (prot)
        break;
      mem[(adr & 'h1f0) | ((adr + i) & 'hf)] = d;
    end
    mst.stop();
    if (!prot)
      ptr = (adr & 'h1f0) | ((adr + cnt) & 'hf);
  endtask

  // random read when sel is set, otherwise current-address read
  task automatic rd(input int adr, input int cnt, input logic sel);
    logic [7:0] d;
    if (sel)
    begin
      mst.start();
      mst.wbyte(dev(adr[8], 1'b0), ack);
      mst.wbyte(adr[7:0], ack);
      cmp_bit("dummy ack", 1'b0, ack);
      ptr = adr;
    end
    mst.start();
    mst.wbyte(dev(ptr[8], 1'b1), ack);
    cmp_bit("read addr ack", 1'b0, ack);
    for (int i = 0; i < cnt; i++)
    begin
      mst.rbyte(i == cnt - 1, d);
      cmp_byte("read data", mem[ptr], d);
      ptr = (ptr + 1) % 512;
    end
    mst.stop();
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    foreach (mem[i])
      mem[i] = 8'hff;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    wait (busy === 1'b0);
    repeat (3) @(posedge clk_in);
    poll(n);
    $display("test power-up done");
    // foreign select bits must be ignored
    mst.start();
    mst.wbyte({DT, ~STRAP[2:1], 2'b00}, ack);
    mst.stop();
    cmp_bit("foreign addr ack", 1'b1, ack);
    rd(rnd(), 3, 1'b1);
    $display("test select done");
    // page overflow, busy window, read across the page end
    a = {1'b0, rnd()};
    wr(a, 18, 1'b0);
    cmp_bit("busy after stop", 1'b1, busy);
    // clock enable low: the write timer must stand still
    @(posedge clk_in) ce <= 1'b0;
    repeat (80) @(posedge clk_in);
    cmp_bit("busy frozen", 1'b1, busy);
    ce <= 1'b1;
    poll(n);
    cmp_bit("poll nack while busy", 1'b1, n > 1);
    rd(a & 'h1f0, 20, 1'b1);
    rd(0, 2, 1'b0);
    $display("test page write done");
    // protection covers only the upper half
    @(posedge clk_in) wp_in <= 1'b1;
    a = {1'b1, rnd()};
    wr(a, 2, 1'b1);
    rd(a, 1, 1'b1);
    wr({1'b0, rnd()}, 1, 1'b0);
    poll(n);
    @(posedge clk_in) wp_in <= 1'b0;
    $display("test write protect done");
    // array end wraps to zero
    wr(9'h1ff, 1, 1'b0);
    poll(n);
    rd(9'h1ff, 2, 1'b1);
    $display("test array wrap done");
    // supply dip: logic restarts, the array keeps its bytes
    @(posedge clk_in) sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    cmp_bit("busy in reset", 1'b1, busy);
    cmp_bit("line in reset", 1'b0, sda_oe_out);
    cmp_bit("drive value", 1'b0, sda_out);
    sys_rst_in <= 1'b0;
    wait (busy === 1'b0);
    repeat (3) @(posedge clk_in);
    poll(n);
    ptr = 0;
    rd(0, 2, 1'b0);
    $display("test reset done");
    tally_and_finish();
  end

  // watchdog
  initial
  begin
    #400000;
    error_cnt++;
    tally_and_finish();
  end
endmodule // i2c_eeprom_slave_interface_tb
